// ### sim/ubg_shift_peer.sv
// Partner: external shift register on the mode-0 pins
`default_nettype none
module ubg_shift_peer (
  input  wire logic       txdOut,
  input  wire logic       rxdOut,
  input  wire logic       rxdOutEnN,
  input  wire logic [7:0] sendByte,
  input  wire logic       arm,
  output logic            rxdPin,
  output logic [7:0]      gotByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] outSr   = 8'h00;
  logic [3:0] outLeft = 4'h0;
  logic       lastBit = 1'b0;
  logic       peerBit;
  // Spent line shows the inverse so a late sample cannot pass by luck
  assign peerBit = (outLeft != 4'h0) ? outSr[0] : ~lastBit;
  // Wire level: the device wins while its enable is low
  assign rxdPin = rxdOutEnN ? peerBit : rxdOut;
  initial gotByte = 8'h00;
  // Load a byte to offer
  always @(posedge arm) begin
    outSr = sendByte;
    outLeft = 4'h8;
  end
  // Capture on rising clock, advance only after the device sampled
  always @(posedge txdOut) begin
    if (!rxdOutEnN) begin
      gotByte = {rxdOut, gotByte[7:1]}; // LSB first
    end else if (outLeft != 4'h0) begin
      lastBit = outSr[0];
      outSr = outSr >> 1;
      outLeft = outLeft - 4'h1;
    end
  end
endmodule : ubg_shift_peer
`default_nettype wire

// ### sim/ubg_top_assertions.sv
// Checker: port-level timing of the baud and shift engine
`default_nettype none
module ubg_checker (
  input wire logic                 ref_clk,
  input wire logic                 rstn,
  input wire ubg_pkg::ubg_bus_s    busIn,
  input wire logic [7:0]           rdData,
  input wire logic                 rxdOut,
  input wire logic                 rxdOutEnN,
  input wire logic                 txdOut,
  input wire ubg_pkg::ubg_bitclk_s bitClk,
  input wire logic                 mode2Clk
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Helper counters
  logic [6:0] gapCnt;
  logic       gapSeen;
  logic [3:0] fallCnt;
  logic       clkPrev;
  // Gap between mode-2 pulses; any power control write voids the next gap
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt  <= 7'h00;
      gapSeen <= 1'b0;
    end else begin
      gapCnt  <= mode2Clk ? 7'h01 : gapCnt + 7'h01;
      if (busIn.wr && busIn.addr == ubg_pkg::OFS_PWR) begin
        gapSeen <= 1'b0;
      end else if (mode2Clk) begin
        gapSeen <= 1'b1;
      end
    end
  end
  // Shift clock falls seen while the data pin is driven
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fallCnt <= 4'h0;
      clkPrev <= 1'b1;
    end else begin
      clkPrev <= txdOut;
      if (rxdOutEnN) begin
        fallCnt <= 4'h0;
      end else if (clkPrev && !txdOut) begin
        fallCnt <= fallCnt + 4'h1;
      end
    end
  end
  // ==========================================================
  // Assertions
  AST_RD_QUIET: assert property (
    !$past(busIn.rd) |-> rdData == 8'h00)
    else $error("read data outside the answer cycle");
  AST_CLK_LOW: assert property (
    $fell(txdOut) |-> !txdOut [*6] ##1 txdOut)
    else $error("shift clock low span is not three states");
  AST_CLK_HIGH: assert property (
    $rose(txdOut) |-> txdOut [*6])
    else $error("shift clock high span too short");
  AST_DATA_AT_HIGH: assert property (
    !rxdOutEnN && $changed(rxdOut) |-> txdOut)
    else $error("data pin moved while shift clock low");
  AST_EIGHT_SHIFTS: assert property (
    $rose(rxdOutEnN) |-> fallCnt == 4'h8)
    else $error("transfer did not give eight clocks");
  AST_MODE2_GAP: assert property (
    mode2Clk && gapSeen |-> gapCnt >= 7'd32 && gapCnt <= 7'd64)
    else $error("mode-2 pulse spacing wrong");
  AST_U1TX_SPACE: assert property (
    bitClk.u1Tx |=> !bitClk.u1Tx [*8])
    else $error("transmit bit clock too fast");
  AST_U1RX_SPACE: assert property (
    bitClk.u1Rx |=> !bitClk.u1Rx [*8])
    else $error("receive bit clock too fast");
  // Main scenarios reached
  cover property ($rose(rxdOutEnN));
  cover property (mode2Clk && gapSeen && gapCnt == 7'd32);
  cover property (bitClk.u2Tx);
endmodule : ubg_checker
bind ubg_top ubg_checker chk (.ref_clk(ref_clk), .rstn(rstn),
  .busIn(busIn), .rdData(rdData), .rxdOut(rxdOut),
  .rxdOutEnN(rxdOutEnN), .txdOut(txdOut), .bitClk(bitClk),
  .mode2Clk(mode2Clk));
`default_nettype wire

// ### sim/ubg_top_bench.sv
// Testbench: registers, bit clock rates and mode-0 transfers
`default_nettype none
module ubg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } ubg_row_s;
  logic                 ref_clk, rstn, rxdPin, t2ExtInput;
  logic                 t1OvfIn = 1'b0;
  logic                 rxdOut, rxdOutEnN, txdOut, t2ExtIrq, mode2Clk;
  logic                 arm;
  logic [7:0]           rdData, sendByte, gotByte, rv;
  logic [2:0]           t1Div = 3'h0;
  ubg_pkg::ubg_bus_s    busIn;
  ubg_pkg::ubg_bitclk_s bitClk;
  int                   mismatches, n_compared;
  int                   lowCyc = 0;
  int                   cnt [5];
  // Stored bytes, with one unmapped place that must read zero
  ubg_row_s rows [6] = '{
    '{ubg_pkg::OFS_T1RELOAD, 8'hfd, 8'hfd},
    '{ubg_pkg::OFS_TMODE,    8'h20, 8'h20},
    '{ubg_pkg::OFS_CAPLOW,   8'hfe, 8'hfe},
    '{ubg_pkg::OFS_CAPHIGH,  8'hff, 8'hff},
    '{ubg_pkg::OFS_T2LOW,    8'hfe, 8'hfe},
    '{4'hf,                  8'h5a, 8'h00}};
  ubg_top dut (.ref_clk(ref_clk), .rstn(rstn), .busIn(busIn),
    .rdData(rdData), .rxdPin(rxdPin), .t1OvfIn(t1OvfIn),
    .t2ExtInput(t2ExtInput), .rxdOut(rxdOut), .rxdOutEnN(rxdOutEnN),
    .txdOut(txdOut), .t2ExtIrq(t2ExtIrq), .bitClk(bitClk),
    .mode2Clk(mode2Clk));
  ubg_shift_peer peer (.txdOut(txdOut), .rxdOut(rxdOut),
    .rxdOutEnN(rxdOutEnN), .sendByte(sendByte), .arm(arm),
    .rxdPin(rxdPin), .gotByte(gotByte));
  // ==========================================================
  // Clock, Timer 1 overflow stand-in, send-time counter
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    t1Div <= t1Div + 3'h1;
    t1OvfIn <= t1Div[2]; // one overflow per 8 clocks, no irq
    if (rxdOutEnN === 1'b0) lowCyc <= lowCyc + 1;
  end
  // ==========================================================
  // Checking and bus tasks
  task automatic note(input string msg);
    mismatches++;
    $display("MISMATCH t=%0t %s", $time, msg);
  endtask : note
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) note($sformatf("byte %h want %h", got, exp));
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) note($sformatf("bit %b want %b", got, exp));
  endtask : chk1
  // Rates may be off by one pulse at the window edges
  task automatic chkRate(input int got, input int exp);
    n_compared++;
    if (got < exp - 1 || got > exp + 1) begin
      note($sformatf("count %0d want %0d", got, exp));
    end
  endtask : chkRate
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    busIn <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busIn <= '0;
    @(posedge ref_clk);
  endtask : wrReg
  task automatic rdReg(input logic [3:0] a, output logic [7:0] v);
    busIn <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busIn <= '0;
    #1 v = rdData;
    @(posedge ref_clk);
  endtask : rdReg
  task automatic measure(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      cnt[0] += bitClk.u1Tx;
      cnt[1] += bitClk.u1Rx;
      cnt[2] += bitClk.u2Tx;
      cnt[3] += bitClk.u2Rx;
      cnt[4] += mode2Clk;
    end
  endtask : measure
  task automatic waitFlag(input int b);
    repeat (200) begin
      rdReg(ubg_pkg::OFS_CTRL, rv);
      if (rv[b] === 1'b1) break;
    end
    chk1(rv[b], 1'b1);
  endtask : waitFlag
  task automatic results;
    $display("mismatches=%0d compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    note("watchdog expired");
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    busIn = '0;
    t2ExtInput = 1'b1;
    sendByte = 8'h35; // not a bit palindrome, so order shows
    arm = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    chk8(rdData, 8'h00);
    chk8({rxdOutEnN, rxdOut, txdOut, t2ExtIrq, bitClk}, 8'he0);
    @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rdReg(ubg_pkg::OFS_PWR, rv);
    chk8(rv, ubg_pkg::PWR_RST);
    foreach (rows[i]) begin
      wrReg(rows[i].a, rows[i].d);
      rdReg(rows[i].a, rv);
      chk8(rv, rows[i].e);
    end
    wrReg(ubg_pkg::OFS_T2HIGH, 8'hff); // counts set while stopped
    wrReg(ubg_pkg::OFS_T2CTRL, 8'h34); // both selects and run
    measure(2560);
    chkRate(cnt[0], 40);
    chkRate(cnt[1], 40);
    chkRate(cnt[2], 10);
    chkRate(cnt[3], 10);
    chkRate(cnt[4], 40);
    rdReg(ubg_pkg::OFS_T2CTRL, rv);
    chk1(rv[ubg_pkg::T2_OVF], 1'b0);
    wrReg(ubg_pkg::OFS_PWR, 8'ha0);
    measure(2560);
    chkRate(cnt[0], 40);
    chkRate(cnt[2], 40);
    chkRate(cnt[3], 20);
    chkRate(cnt[4], 80);
    wrReg(ubg_pkg::OFS_T2CTRL, 8'h3c);
    t2ExtInput <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 chk1(t2ExtIrq, 1'b1);
    wrReg(ubg_pkg::OFS_CTRL, 8'h00);
    wrReg(ubg_pkg::OFS_BUF, 8'hc5);
    waitFlag(ubg_pkg::CTRL_TXD);
    chk8(gotByte, 8'hc5);
    chkRate(lowCyc, 97);
    arm <= 1'b1;
    wrReg(ubg_pkg::OFS_CTRL, 8'h10);
    waitFlag(ubg_pkg::CTRL_RXD);
    rdReg(ubg_pkg::OFS_BUF, rv);
    chk8(rv, 8'h35);
    results();
  end
endmodule : ubg_top_bench
`default_nettype wire

// ### verilog/ubg_pkg.sv
// Package: constants and carriers for the baud generator and shift mode
`default_nettype none
package ubg_pkg;
  // ==========================================================
  // Register offsets (plain register port, byte addresses)
  localparam logic [3:0] OFS_CTRL     = 4'h0; // serial_control_reg
  localparam logic [3:0] OFS_BUF      = 4'h1; // serial_buffer
  localparam logic [3:0] OFS_T2CTRL   = 4'h2; // timer2_control_reg
  localparam logic [3:0] OFS_PWR      = 4'h3; // power_control_reg
  localparam logic [3:0] OFS_T1RELOAD = 4'h4; // timer1_reload_byte
  localparam logic [3:0] OFS_T2LOW    = 4'h5; // timer2_low_byte
  localparam logic [3:0] OFS_T2HIGH   = 4'h6; // timer2_high_byte
  localparam logic [3:0] OFS_CAPLOW   = 4'h7; // t2_reload_low
  localparam logic [3:0] OFS_CAPHIGH  = 4'h8; // t2_reload_high
  localparam logic [3:0] OFS_TMODE    = 4'h9; // timer_mode_reg
  localparam logic [3:0] OFS_STATUS   = 4'ha; // tx pending, send/receive activity and baud mode
  // ==========================================================
  // Field positions
  localparam int CTRL_MODE0 = 7;  // mode bit 0
  localparam int CTRL_MODE1 = 6;  // mode bit 1
  localparam int CTRL_RXEN  = 4;
  localparam int CTRL_TXD   = 1;  // tx_done_flag
  localparam int CTRL_RXD   = 0;  // rx_done_flag
  localparam int T2_OVF     = 7;  // timer2_overflow_flag
  localparam int T2_EXTF    = 6;  // t2_ext_flag
  localparam int T2_RXSEL   = 5;
  localparam int T2_TXSEL   = 4;  // tx_clock_select
  localparam int T2_EXTEN   = 3;  // t2_ext_trigger_enable
  localparam int T2_RUN     = 2;  // timer2_run
  localparam int T2_CNTSEL  = 1;  // timer2_count_select
  localparam int PWR_DBL    = 7;  // baud_double_bit
  localparam int PWR_U2TX   = 5;  // uart2_tx_clock_select
  localparam int PWR_U2RX   = 4;  // uart2_rx_clock_select
  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PWR_RST  = 8'h00;
  localparam logic [7:0] TIMER_MODE_REG_RST = 8'h00;
  localparam logic [3:0] TIMER_MODE_REG_AUTO8  = 4'h2;
  localparam logic [3:0] TIMER_MODE_REG_T16    = 4'h1;
  localparam logic [1:0] PHASE_LAST  = 2'h1;  // two phases per state
  localparam logic [2:0] STATE_LAST  = 3'h5;  // six states S1..S6
  localparam logic [3:0] DIV16_LAST  = 4'hf;
  localparam logic [4:0] DIV32_LAST  = 5'h1f;
  localparam logic [5:0] DIV64_LAST  = 6'h3f;
  localparam logic [8:0] TX_LOAD     = 9'h100; // marker above data byte
  localparam logic [8:0] RX_PRELOAD  = 9'h1fe; // 111111110
  // Machine state numbering: S1=0 .. S6=5
  localparam logic [2:0] ST_S1 = 3'h0;
  localparam logic [2:0] ST_S2 = 3'h1;
  localparam logic [2:0] ST_S3 = 3'h2;
  localparam logic [2:0] ST_S5 = 3'h4;
  localparam logic [2:0] ST_S6 = 3'h5;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SM_IDLE = 2'b00,
    SM_WAIT = 2'b01,
    SM_RUN  = 2'b10,
    SM_LAST = 2'b11
  } ubg_seq_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ubg_bus_s;
  typedef struct packed {
    logic u1Tx;
    logic u1Rx;
    logic u2Tx;
    logic u2Rx;
  } ubg_bitclk_s;
endpackage : ubg_pkg
`default_nettype wire

// ### verilog/ubg_top.sv
// Baud generation for two UARTs and the Mode 0 shift-register engine
`default_nettype none
module ubg_top (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire ubg_pkg::ubg_bus_s  busIn,
  output logic [7:0]              rdData,
  input  wire logic               rxdPin,
  input  wire logic               t1OvfIn,
  input  wire logic               t2ExtInput,
  output logic                    rxdOut,
  output logic                    rxdOutEnN,
  output logic                    txdOut,
  output logic                    t2ExtIrq,
  output ubg_pkg::ubg_bitclk_s    bitClk,
  output logic                    mode2Clk
);
  // ==========================================================
  // Registers
  logic [7:0]  ctrl_reg, t2ctrl_reg, pwr_reg, tmode_reg, t1reload_reg;
  logic [7:0]  rxbuf_reg, txbuf_reg;
  logic [15:0] t2cnt_reg, t2cap_reg;
  logic        phase_reg;
  logic [2:0]  state_reg;
  logic        rxSync1_reg, rxSync2_reg, extSync1_reg, extSync2_reg;
  logic        extPrev_reg, rxSample_reg;
  logic [8:0]  txShift_reg, rxShift_reg;
  logic        txPend_reg, sendAct_reg, txLast_reg;
  logic        rxStart_reg, recvAct_reg, rxLast_reg;
  ubg_pkg::ubg_seq_e txSeq_reg, rxSeq_reg;
  logic [4:0]  t1Div_reg;
  logic [3:0]  t2Div_reg;
  logic [5:0]  m2Div_reg;
  logic        t1OvfSync1_reg, t1OvfSync2_reg, t1OvfPrev_reg;

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input ubg_pkg::ubg_bus_s b,
                               input logic [3:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction : hit

  logic mode0, baudMode, t2Timer, stateTick, t2Tick, t2Roll;
  logic s6p2, s1p1, s3p1, s5p2, s6p1, extFall, t1Ovf, t2Ovf;
  logic txSel1, rxSel1;
  assign mode0 = !ctrl_reg[ubg_pkg::CTRL_MODE0]
               && !ctrl_reg[ubg_pkg::CTRL_MODE1];
  // UART1 selects in Timer 2 control, UART2 in power control
  assign txSel1 = t2ctrl_reg[ubg_pkg::T2_TXSEL];
  assign rxSel1 = t2ctrl_reg[ubg_pkg::T2_RXSEL];
  // Any select bit puts Timer 2 in baud mode
  assign baudMode = txSel1 || rxSel1 || pwr_reg[ubg_pkg::PWR_U2TX]
                  || pwr_reg[ubg_pkg::PWR_U2RX];
  assign t2Timer = !t2ctrl_reg[ubg_pkg::T2_CNTSEL];
  // Machine-cycle strobes: phase index 1 is P2
  assign stateTick = phase_reg;
  assign s1p1 = (state_reg == ubg_pkg::ST_S1) && !phase_reg;
  assign s3p1 = (state_reg == ubg_pkg::ST_S3) && !phase_reg;
  assign s6p1 = (state_reg == ubg_pkg::ST_S6) && !phase_reg;
  assign s5p2 = (state_reg == ubg_pkg::ST_S5) && phase_reg;
  assign s6p2 = (state_reg == ubg_pkg::ST_S6) && phase_reg;
  assign extFall = extPrev_reg && !extSync2_reg;
  assign t1Ovf = t1OvfSync2_reg && !t1OvfPrev_reg;

  // ==========================================================
  // Oscillator phase and state counter (ref_clk is the oscillator)
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 1'b0;
      state_reg <= 3'h0;
    end else begin
      phase_reg <= ~phase_reg;
      if (phase_reg) begin
        state_reg <= (state_reg == ubg_pkg::STATE_LAST) ? 3'h0
                   : state_reg + 3'h1;
      end
    end
  end

  // Two-flop synchronisers for pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxSync1_reg    <= 1'b1;
      rxSync2_reg    <= 1'b1;
      extSync1_reg   <= 1'b1;
      extSync2_reg   <= 1'b1;
      extPrev_reg    <= 1'b1;
      t1OvfSync1_reg <= 1'b0;
      t1OvfSync2_reg <= 1'b0;
      t1OvfPrev_reg  <= 1'b0;
    end else begin
      rxSync1_reg    <= rxdPin;
      rxSync2_reg    <= rxSync1_reg;
      extSync1_reg   <= t2ExtInput;
      extSync2_reg   <= extSync1_reg;
      extPrev_reg    <= extSync2_reg;
      t1OvfSync1_reg <= t1OvfIn;
      t1OvfSync2_reg <= t1OvfSync1_reg;
      t1OvfPrev_reg  <= t1OvfSync2_reg;
    end
  end

  // ==========================================================
  // Timer 2 counting: one step per state time in baud timer mode
  assign t2Tick = t2ctrl_reg[ubg_pkg::T2_RUN]
                && (t2Timer ? stateTick : extFall);
  assign t2Roll = t2Tick && (t2cnt_reg == 16'hffff);
  assign t2Ovf  = t2Roll && baudMode;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t2cnt_reg <= 16'h0000;
    end else if (hit(busIn, ubg_pkg::OFS_T2LOW)) begin
      t2cnt_reg[7:0] <= busIn.wdata;
    end else if (hit(busIn, ubg_pkg::OFS_T2HIGH)) begin
      t2cnt_reg[15:8] <= busIn.wdata;
    end else if (t2Roll && baudMode) begin
      t2cnt_reg <= t2cap_reg;
    end else if (t2Tick) begin
      t2cnt_reg <= t2cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t2cap_reg <= 16'h0000;
    end else if (hit(busIn, ubg_pkg::OFS_CAPLOW)) begin
      t2cap_reg[7:0] <= busIn.wdata;
    end else if (hit(busIn, ubg_pkg::OFS_CAPHIGH)) begin
      t2cap_reg[15:8] <= busIn.wdata;
    end
  end

  // Timer 2 control; flags set by hardware win over software writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t2ctrl_reg <= 8'h00;
    end else begin
      if (hit(busIn, ubg_pkg::OFS_T2CTRL)) begin
        t2ctrl_reg <= busIn.wdata;
      end
      // Baud rollovers never touch the overflow flag
      if (t2Roll && !baudMode) begin
        t2ctrl_reg[ubg_pkg::T2_OVF] <= 1'b1;
      end
      // Edge only flags, reload suppressed in baud mode
      if (extFall && t2ctrl_reg[ubg_pkg::T2_EXTEN]) begin
        t2ctrl_reg[ubg_pkg::T2_EXTF] <= 1'b1;
      end
    end
  end

  // Other software registers; double bit resets to zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_reg      <= ubg_pkg::PWR_RST;
      tmode_reg    <= ubg_pkg::TIMER_MODE_REG_RST;
      t1reload_reg <= 8'h00;
    end else begin
      if (hit(busIn, ubg_pkg::OFS_PWR))      pwr_reg      <= busIn.wdata;
      if (hit(busIn, ubg_pkg::OFS_TMODE))    tmode_reg    <= busIn.wdata;
      if (hit(busIn, ubg_pkg::OFS_T1RELOAD)) t1reload_reg <= busIn.wdata;
    end
  end

  // ==========================================================
  // Bit clocks: Timer 1 path /32 (or /16 doubled), Timer 2 path /16
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t1Div_reg <= 5'h00;
      t2Div_reg <= 4'h0;
      m2Div_reg <= 6'h00;
    end else begin
      if (t1Ovf) t1Div_reg <= t1Div_reg + 5'h01;
      if (t2Ovf) t2Div_reg <= t2Div_reg + 4'h1;
      m2Div_reg <= m2Div_reg + 6'h01;
    end
  end

  logic t1Bit, t2Bit, m2Bit;
  // Doubling halves the divide: 2^double over 32
  assign t1Bit = t1Ovf && (pwr_reg[ubg_pkg::PWR_DBL]
               ? (t1Div_reg[3:0] == ubg_pkg::DIV16_LAST)
               : (t1Div_reg == ubg_pkg::DIV32_LAST));
  assign t2Bit = t2Ovf && (t2Div_reg == ubg_pkg::DIV16_LAST);
  assign m2Bit = pwr_reg[ubg_pkg::PWR_DBL]
               ? (m2Div_reg[4:0] == ubg_pkg::DIV32_LAST)
               : (m2Div_reg == ubg_pkg::DIV64_LAST);

  // Each bitClk pulse is one bit time of the ten-bit Mode 1 frame
  // Per-direction source pick, registered outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bitClk   <= '0;
      mode2Clk <= 1'b0;
      t2ExtIrq <= 1'b0;
    end else begin
      bitClk.u1Tx <= txSel1 ? t2Bit : t1Bit;
      bitClk.u1Rx <= rxSel1 ? t2Bit : t1Bit;
      bitClk.u2Tx <= pwr_reg[ubg_pkg::PWR_U2TX] ? t2Bit : t1Bit;
      bitClk.u2Rx <= pwr_reg[ubg_pkg::PWR_U2RX] ? t2Bit : t1Bit;
      mode2Clk    <= m2Bit;
      t2ExtIrq    <= t2ctrl_reg[ubg_pkg::T2_EXTF];
    end
  end

  // ==========================================================
  // Mode 0 transmit: write at S6P2, send one cycle on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txbuf_reg   <= 8'h00;
      txShift_reg <= 9'h000;
      txPend_reg  <= 1'b0;
      sendAct_reg <= 1'b0;
      txLast_reg  <= 1'b0;
      txSeq_reg   <= ubg_pkg::SM_IDLE;
    end else begin
      case (txSeq_reg)
        ubg_pkg::SM_IDLE: begin
          if (txPend_reg && mode0 && s6p2) begin
            txShift_reg <= ubg_pkg::TX_LOAD | {1'b0, txbuf_reg};
            txPend_reg  <= 1'b0;
            txSeq_reg   <= ubg_pkg::SM_WAIT;
          end
        end
        ubg_pkg::SM_WAIT: begin
          if (s6p2) begin
            sendAct_reg <= 1'b1;
            txSeq_reg   <= ubg_pkg::SM_RUN;
          end
        end
        ubg_pkg::SM_RUN: begin
          // Shift right, zeros from left, LSB first
          if (s6p2) begin
            txShift_reg <= {1'b0, txShift_reg[8:1]};
            if (txShift_reg[8:1] == 8'h01) begin
              txSeq_reg <= ubg_pkg::SM_LAST;
            end
          end
        end
        ubg_pkg::SM_LAST: begin
          if (s1p1) begin
            sendAct_reg <= 1'b0;
            txLast_reg  <= 1'b1;
            txSeq_reg   <= ubg_pkg::SM_IDLE;
          end
        end
        default: txSeq_reg <= ubg_pkg::SM_IDLE;
      endcase
      // After the load, so a write in the load cycle stays queued
      if (hit(busIn, ubg_pkg::OFS_BUF)) begin
        txbuf_reg  <= busIn.wdata;
        txPend_reg <= 1'b1;
      end
      if (txLast_reg) txLast_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Mode 0 receive: start on enable and clear flag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxShift_reg  <= 9'h1ff;
      rxbuf_reg    <= 8'h00;
      rxStart_reg  <= 1'b0;
      recvAct_reg  <= 1'b0;
      rxLast_reg   <= 1'b0;
      rxSample_reg <= 1'b1;
      rxSeq_reg    <= ubg_pkg::SM_IDLE;
    end else begin
      rxLast_reg <= 1'b0;
      if (recvAct_reg && s5p2) rxSample_reg <= rxSync2_reg;
      case (rxSeq_reg)
        ubg_pkg::SM_IDLE: begin
          if (mode0 && ctrl_reg[ubg_pkg::CTRL_RXEN]
              && !ctrl_reg[ubg_pkg::CTRL_RXD] && s6p2) begin
            rxSeq_reg <= ubg_pkg::SM_WAIT;
          end
        end
        ubg_pkg::SM_WAIT: begin
          if (s6p2) begin
            rxShift_reg <= ubg_pkg::RX_PRELOAD;
            rxStart_reg <= 1'b1;
            rxSeq_reg   <= ubg_pkg::SM_RUN;
          end
        end
        ubg_pkg::SM_RUN: begin
          // Active one phase after the preload
          if (rxStart_reg) begin
            recvAct_reg <= 1'b1;
            rxStart_reg <= 1'b0;
          end
          if (recvAct_reg && s6p2) begin
            rxShift_reg <= {rxShift_reg[7:0], rxSample_reg};
            if (!rxShift_reg[7]) begin
              // First bit in sits highest; reverse so bit 0 is first
              rxbuf_reg <= {rxSample_reg, rxShift_reg[0], rxShift_reg[1],
                            rxShift_reg[2], rxShift_reg[3], rxShift_reg[4],
                            rxShift_reg[5], rxShift_reg[6]};
              rxSeq_reg <= ubg_pkg::SM_LAST;
            end
          end
        end
        ubg_pkg::SM_LAST: begin
          if (s1p1) begin
            recvAct_reg <= 1'b0;
            rxLast_reg  <= 1'b1;
            rxSeq_reg   <= ubg_pkg::SM_IDLE;
          end
        end
        default: rxSeq_reg <= ubg_pkg::SM_IDLE;
      endcase
    end
  end

  // Serial control; hardware set wins over software clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= ubg_pkg::CTRL_RST;
    end else begin
      if (hit(busIn, ubg_pkg::OFS_CTRL)) ctrl_reg <= busIn.wdata;
      if (txLast_reg) ctrl_reg[ubg_pkg::CTRL_TXD] <= 1'b1;
      if (rxLast_reg) ctrl_reg[ubg_pkg::CTRL_RXD] <= 1'b1;
    end
  end

  // ==========================================================
  // Pins: shift clock low S3..S5, high otherwise
  logic clkLow;
  assign clkLow = (state_reg >= ubg_pkg::ST_S3)
                && (state_reg < ubg_pkg::ST_S6);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txdOut    <= 1'b1;
      rxdOut    <= 1'b1;
      rxdOutEnN <= 1'b1;
    end else begin
      txdOut    <= (sendAct_reg || recvAct_reg) ? !clkLow : 1'b1;
      rxdOut    <= txShift_reg[0];
      rxdOutEnN <= !sendAct_reg;
    end
  end

  // Read port: data in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 8'h00;
    end else if (busIn.rd) begin
      case (busIn.addr)
        ubg_pkg::OFS_CTRL:     rdData <= ctrl_reg;
        ubg_pkg::OFS_BUF:      rdData <= rxbuf_reg;
        ubg_pkg::OFS_T2CTRL:   rdData <= t2ctrl_reg;
        ubg_pkg::OFS_PWR:      rdData <= pwr_reg;
        ubg_pkg::OFS_T1RELOAD: rdData <= t1reload_reg;
        ubg_pkg::OFS_T2LOW:    rdData <= t2cnt_reg[7:0];
        ubg_pkg::OFS_T2HIGH:   rdData <= t2cnt_reg[15:8];
        ubg_pkg::OFS_CAPLOW:   rdData <= t2cap_reg[7:0];
        ubg_pkg::OFS_CAPHIGH:  rdData <= t2cap_reg[15:8];
        ubg_pkg::OFS_TMODE:    rdData <= tmode_reg;
        ubg_pkg::OFS_STATUS:   rdData <= {4'h0, txPend_reg, sendAct_reg,
                                          recvAct_reg, baudMode};
        default:               rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end
endmodule : ubg_top
`default_nettype wire
